// [xpc_consts.svh]
/*
  timing counts and field layout for the crosspoint memory controller.
  assumes a 100 MHz core clock; times in ns, counts derived by rounding up.
*/
`ifndef XPC_CONSTS_SVH
`define XPC_CONSTS_SVH

`define XPC_CLK_PERIOD_NS  10
`define XPC_T_SETUP_NS     10
`define XPC_T_HOLD_NS      10
`define XPC_T_STROBE_NS    20
`define XPC_T_RESET_NS     40
`define XPC_SETUP_CYC  ((`XPC_T_SETUP_NS + `XPC_CLK_PERIOD_NS - 1) / `XPC_CLK_PERIOD_NS)
`define XPC_HOLD_CYC   ((`XPC_T_HOLD_NS + `XPC_CLK_PERIOD_NS - 1) / `XPC_CLK_PERIOD_NS)
`define XPC_STROBE_CYC ((`XPC_T_STROBE_NS + `XPC_CLK_PERIOD_NS - 1) / `XPC_CLK_PERIOD_NS)
`define XPC_RESET_CYC  ((`XPC_T_RESET_NS + `XPC_CLK_PERIOD_NS - 1) / `XPC_CLK_PERIOD_NS)
`define XPC_ROW_LSB    0
`define XPC_COL_LSB    3

`endif

// [xpc_pkg.sv]
/*
  types for the crosspoint memory controller.
  assumes nothing beyond the consts header.
*/
package xpc_pkg;

  typedef enum logic [2:0] {
    XPC_IDLE   = 3'b000,
    XPC_SETUP  = 3'b001,
    XPC_STROBE = 3'b010,
    XPC_HOLD   = 3'b011,
    XPC_CLEAR  = 3'b100
  } xpc_state_t;

  // pins toward the crosspoint memory
  typedef struct packed {
    logic [2:0] column_select;
    logic [2:0] row_select;
    logic       data;
    logic       strobe;
    logic       reset;
  } xpc_pins_t;

endpackage

// [xpc_ctrl.sv]
/*
  controller driving the control memory of an 8x8 crosspoint switch
  through its address, data, strobe and reset pins; each write runs as
  a setup phase, a strobe pulse and a hold phase, a clear as one reset pulse.
  assumes requests come from logic on i_core_clk, so no synchroniser stands
  on the request inputs.
  assumes the device needs no clock and follows its data while strobe is high.
  phase lengths default to the consts header counts at a 100 MHz core clock;
  a request made while busy is dropped without notice.
*/
// Functional notes
// RL1: one bit per row/column pair
// RL2: 64 write-only bits, six select lines
// RL3: bit enable is strobe AND address match
// RL4: one data input shared by all bits
// RL5: addressed bit follows data while strobe high
// RL6: strobe fall captures data
// RL7: one closes switch, zero opens it
// RL8: write changes only the addressed bit
// RL9: any bit combination may be set
// RL10: reset clears all bits immediately
// RL11: reset held low throughout a write
// RL12: write is strobe raised then lowered
// RL13: selects settled before strobe, steady during
// RL14: data steady across strobe falling edge
// RL15: three bits row, three bits column, binary
// RL16: reset wins over a concurrent write
`timescale 1ns/1ps
`include "xpc_consts.svh"

module xpc_ctrl
  import xpc_pkg::*;
#(
  parameter int SETUP_CYC  = `XPC_SETUP_CYC,
  parameter int HOLD_CYC   = `XPC_HOLD_CYC,
  parameter int STROBE_CYC = `XPC_STROBE_CYC,
  parameter int RESET_CYC  = `XPC_RESET_CYC
) (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  // write request
  input  wire logic       i_wr_req,
  input  wire logic [2:0] i_wr_row,
  input  wire logic [2:0] i_wr_col,
  input  wire logic       i_wr_on,
  // clear-all request
  input  wire logic       i_clr_req,
  // status
  output logic            o_busy,
  output logic            o_done,
  // device pins
  output logic [2:0]      o_row_select,
  output logic [2:0]      o_column_select,
  output logic            o_data,
  output logic            o_strobe,
  output logic            o_dev_reset
);

  // phase lengths in core cycles; eight bits bound any phase to 255 cycles
  localparam logic [7:0] SETUP_N  = 8'(SETUP_CYC);
  localparam logic [7:0] HOLD_N   = 8'(HOLD_CYC);
  localparam logic [7:0] STROBE_N = 8'(STROBE_CYC);
  localparam logic [7:0] RESET_N  = 8'(RESET_CYC);

  // sequencer
  xpc_state_t state_r;
  xpc_state_t state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       last;
  logic       take_wr;
  logic       take_clr;
  logic       state_chg;

  // device pins and status
  xpc_pins_t  pins_r;
  logic       strobe_nxt;
  logic       dev_reset_nxt;
  logic       busy_nxt;
  logic       done_nxt;

  // only an idle sequencer takes a request; clear wins over write
  assign take_clr  = (state_r == XPC_IDLE) && i_clr_req;
  assign take_wr   = (state_r == XPC_IDLE) && i_wr_req && !i_clr_req;
  assign state_chg = (state_nxt != state_r);
  // zero-length phase still lasts one cycle instead of hanging
  assign last      = (cnt_r <= 8'h01);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      XPC_IDLE: begin
        // clear and write never overlap, so device reset cannot cut a strobe
        if (take_clr) begin
          state_nxt = XPC_CLEAR; // RL16
        end else if (take_wr) begin
          state_nxt = XPC_SETUP;
        end
      end
      XPC_SETUP: begin
        if (last) begin
          state_nxt = XPC_STROBE; // RL12
        end
      end
      XPC_STROBE: begin
        if (last) begin
          state_nxt = XPC_HOLD;
        end
      end
      XPC_HOLD: begin
        // strobe already low; address and data still stand past its fall
        if (last) begin
          state_nxt = XPC_IDLE; // RL14
        end
      end
      XPC_CLEAR: begin
        if (last) begin
          state_nxt = XPC_IDLE;
        end
      end
      default: begin
        state_nxt = XPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_r <= XPC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // phase counter, loaded with the length of each state as it is entered
  always_comb begin
    cnt_nxt = cnt_r;
    if (state_chg) begin
      case (state_nxt)
        XPC_SETUP: begin
          cnt_nxt = SETUP_N;
        end
        XPC_STROBE: begin
          cnt_nxt = STROBE_N;
        end
        XPC_HOLD: begin
          cnt_nxt = HOLD_N;
        end
        XPC_CLEAR: begin
          cnt_nxt = RESET_N;
        end
        default: begin
          cnt_nxt = 8'h00;
        end
      endcase
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // pin levels for the phase about to be entered
  always_comb begin
    strobe_nxt    = (state_nxt == XPC_STROBE);
    dev_reset_nxt = (state_nxt == XPC_CLEAR);
  end

  // address and data latched once per write, so they stay steady under the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pins_r.row_select    <= 3'h0;
      pins_r.column_select <= 3'h0;
      pins_r.data          <= 1'b0;
      pins_r.strobe        <= 1'b0;
      pins_r.reset         <= 1'b0;
    end else begin
      if (take_wr) begin
        pins_r.row_select    <= i_wr_row; // RL15
        pins_r.column_select <= i_wr_col; // RL13
        pins_r.data          <= i_wr_on; // RL7
      end
      pins_r.strobe <= strobe_nxt; // RL12
      pins_r.reset  <= dev_reset_nxt; // RL11
    end
  end

  // outputs come straight from the pin flip-flops
  assign o_row_select    = pins_r.row_select;
  assign o_column_select = pins_r.column_select;
  assign o_data          = pins_r.data;
  assign o_strobe        = pins_r.strobe;
  assign o_dev_reset     = pins_r.reset;

  // status follows the state the sequencer is about to enter
  always_comb begin
    busy_nxt = (state_nxt != XPC_IDLE);
    done_nxt = (state_r != XPC_IDLE) && (state_nxt == XPC_IDLE);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= busy_nxt;
    end
  end

  // done is a single-cycle pulse; nothing holds it
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_done <= 1'b0;
    end else begin
      o_done <= done_nxt;
    end
  end

endmodule

// [xpc_ctrl_properties.sv]
/* pin checks for the crosspoint controller.
   bound to xpc_ctrl ports; default cycle counts assumed. */
`timescale 1ns/1ps
module xpc_ctrl_properties (
  input wire logic       i_core_clk,
  input wire logic       i_reset,
  input wire logic       o_done,
  input wire logic [2:0] o_row_select,
  input wire logic [2:0] o_column_select,
  input wire logic       o_data,
  input wire logic       o_strobe,
  input wire logic       o_dev_reset
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_pulse;
    o_strobe [*2] ##1 !o_strobe;
  endsequence
  a_no_rst_write: assert property (o_strobe |-> !o_dev_reset)
    else $error("device reset during strobe");
  a_strobe_pulse: assert property ($rose(o_strobe) |-> s_pulse ##1 o_done)
    else $error("strobe pulse wrong");
  a_sel_steady: assert property (o_strobe |-> $stable({o_row_select, o_column_select}))
    else $error("selects moved under strobe");
  a_data_hold: assert property ($fell(o_strobe) |-> $stable(o_data))
    else $error("data moved at strobe fall");
endmodule

// [xpc_mem_model.sv]
/* device model: 64 latched switch bits.
   driven straight from the controller pins. */
`timescale 1ns/1ps
module xpc_mem_model (
  input wire logic [5:0] i_addr,
  input wire logic       i_data,
  input wire logic       i_strobe,
  input wire logic       i_reset,
  output logic [63:0]    o_sw
);
  // column in the high bits; latch, so no clock
  always @* begin
    if (i_reset) o_sw = '0;
    else if (i_strobe) o_sw[i_addr] = i_data;
  end
endmodule

// [xpc_ctrl_bench.sv]
/* self-checking bench for xpc_ctrl with a memory model.
   needs xpc_pkg, xpc_mem_model and the checker. */
`timescale 1ns/1ps
`include "xpc_consts.svh"
module xpc_ctrl_bench;
  logic        i_core_clk = 0, i_reset = 1, i_wr_req = 0, i_wr_on = 0, i_clr_req = 0;
  logic [2:0]  i_wr_row = 0, i_wr_col = 0, o_row_select, o_column_select;
  logic        o_busy, o_done, o_data, o_strobe, o_dev_reset;
  logic [63:0] sw, exp_sw;
  int          failures = 0, tests_run = 0;
  integer      seed = 65033;
  initial forever #5 i_core_clk = ~i_core_clk;
  xpc_ctrl u_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_wr_req(i_wr_req),
    .i_wr_row(i_wr_row), .i_wr_col(i_wr_col), .i_wr_on(i_wr_on), .i_clr_req(i_clr_req),
    .o_busy(o_busy), .o_done(o_done), .o_row_select(o_row_select),
    .o_column_select(o_column_select), .o_data(o_data), .o_strobe(o_strobe),
    .o_dev_reset(o_dev_reset));
  xpc_mem_model u_mem (.i_addr({o_column_select, o_row_select}), .i_data(o_data),
    .i_strobe(o_strobe), .i_reset(o_dev_reset), .o_sw(sw));
  task automatic chk(logic [63:0] seen, logic [63:0] want);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t map %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // row flips while busy: a wrongly taken repeat hits another bit
  task automatic req(logic wr, logic clr, logic [2:0] r, logic [2:0] c, logic v);
    int n;
    int want_n;
    want_n = clr ? `XPC_RESET_CYC : `XPC_SETUP_CYC + `XPC_STROBE_CYC + `XPC_HOLD_CYC;
    @(posedge i_core_clk);
    i_wr_req <= wr;
    i_clr_req <= clr;
    i_wr_row <= r;
    i_wr_col <= c;
    i_wr_on <= v;
    @(posedge i_core_clk);
    i_wr_row <= ~r;
    @(posedge i_core_clk);
    i_wr_req <= 0;
    i_clr_req <= 0;
    for (n = 0; n < 20 && o_done !== 1'b1; n++) begin
      @(negedge i_core_clk);
      if (o_done !== 1'b1) chk(o_busy, 1'b1);
    end
    chk(o_done, 1'b1);
    chk(n, want_n);
    chk(o_busy, 1'b0);
    if (clr) exp_sw = '0;
    else exp_sw[{c, r}] = v;
    chk(sw, exp_sw);
  endtask
  initial begin
    int i;
    exp_sw = '0;
    repeat (5) @(posedge i_core_clk);
    i_reset <= 0;
    @(negedge i_core_clk);
    chk({o_busy, o_done, o_strobe, o_dev_reset}, 4'h0);
    req(0, 1, 0, 0, 0);
    $display("clear test done");
    req(1, 0, 0, 0, 1);
    req(1, 0, 7, 7, 1);
    for (i = 0; i < 40; i++) req(1, 0, 3'($random(seed)), 3'($random(seed)), 1'($random(seed)));
    $display("write test done");
    req(1, 1, 3, 3, 1);
    $display("clear priority test done");
    end_sim;
  end
  initial begin
    #20000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim;
  end
endmodule
bind xpc_ctrl xpc_ctrl_properties u_prop (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .o_done(o_done), .o_row_select(o_row_select), .o_column_select(o_column_select),
  .o_data(o_data), .o_strobe(o_strobe), .o_dev_reset(o_dev_reset));
